// File: ces_regs.vh
// Register offsets, field positions, reset values and counts for the error and status block
`ifndef CES_REGS_VH
`define CES_REGS_VH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define CES_OFF_RESET_REGISTER 8'h00
`define CES_OFF_MODE_SELECT 8'h04
`define CES_OFF_ERROR_COUNTERS 8'h10
`define CES_OFF_ERROR_TYPE_FLAGS 8'h14
`define CES_OFF_CORE_STATUS 8'h18
`define CES_OFF_FILTER_CONTROL 8'h60

// ****************************************************************
// Field positions
// ****************************************************************
`define CES_SOFT_RESET_BIT 0
`define CES_CORE_ENABLE_BIT 1
`define CES_SEL_SLEEP 0
`define CES_SEL_LOOPBACK 1
`define CES_EC_RX_HI 15
`define CES_EC_RX_LO 8
`define CES_EC_TX_HI 7
`define CES_EC_TX_LO 0
`define CES_EF_ACK 4
`define CES_EF_BIT 3
`define CES_EF_STUFF 2
`define CES_EF_FORM 1
`define CES_EF_CRC 0
`define CES_EF_WIDTH 5
`define CES_ST_FILTER_BUSY 11
`define CES_ST_TX_FIFO_FULL 10
`define CES_ST_HP_BUFFER_FULL 9
`define CES_ST_FAULT_HI 8
`define CES_ST_FAULT_LO 7
`define CES_ST_ERROR_WARNING 6
`define CES_ST_BUS_BUSY 5
`define CES_ST_BUS_IDLE 4
`define CES_ST_NORMAL 3
`define CES_ST_SLEEP 2
`define CES_ST_LOOPBACK 1
`define CES_ST_CONFIG 0

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define CES_FAULT_CONFIG 2'b00
`define CES_FAULT_ACTIVE 2'b01
`define CES_FAULT_PASSIVE 2'b11
`define CES_FAULT_BUS_OFF 2'b10
`define CES_CONFIG_RESET 1'b1

// ****************************************************************
// Counts and thresholds
// ****************************************************************
`define CES_RECESSIVE_RUN 4'd11
`define CES_RECOVERY_RUNS 8'd128
`define CES_WARN_LEVEL 9'd96
`define CES_PASSIVE_LEVEL 9'd127
`define CES_BUS_OFF_LEVEL 9'd255
`define CES_RX_CEILING 9'd255
`define CES_RX_PASSIVE_RETURN 9'd119
`define CES_ERR_STEP_MAJOR 9'd8

`endif

// File: ces_recessive_run.v
// Detector of runs of consecutive recessive bits on the bus receive pin
`include "ces_regs.vh"

module ces_recessive_run (
	input wire clk_i,
	input wire rst_n_i,
	input wire can_rx_i,
	input wire bit_tick_i,
	input wire restart_i,
	output reg run_done_o
);

	reg rx_meta;
	reg rx_sync;
	reg [3:0] run_count;

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= can_rx_i;
			rx_sync <= rx_meta;
		end
	end

	// ****************************************************************
	// Run counter
	// ****************************************************************
	// Count restarts after each run so back to back runs are all seen
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_count <= 4'h0;
			run_done_o <= 1'b0;
		end else begin
			run_done_o <= 1'b0;
			if (restart_i) begin
				run_count <= 4'h0;
			end else if (bit_tick_i) begin
				if (!rx_sync) begin
					run_count <= 4'h0;
				end else if (run_count == `CES_RECESSIVE_RUN - 4'd1) begin
					run_count <= 4'h0;
					run_done_o <= 1'b1;
				end else begin
					run_count <= run_count + 4'd1;
				end
			end
		end
	end

endmodule // ces_recessive_run

// File: ces_status_core.v
// Error counters, error type flags, core status word and their register port
`include "ces_regs.vh"

module ces_status_core #(
	parameter NUM_FILTERS = 4
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	output reg [31:0] reg_rdata_o,
	input wire can_rx_i,
	input wire bit_tick_i,
	input wire frame_active_i,
	input wire tx_err_i,
	input wire rx_err_i,
	input wire rx_err_major_i,
	input wire tx_ok_i,
	input wire rx_ok_i,
	input wire ack_err_i,
	input wire bit_err_i,
	input wire stuff_err_i,
	input wire form_err_i,
	input wire crc_err_i,
	input wire tx_fifo_full_i,
	input wire hp_buffer_full_i,
	input wire filter_done_i,
	output reg core_enable_o,
	output reg loopback_o,
	output reg sleep_o,
	output reg bus_off_o,
	output reg filter_locked_o
);

	localparam FW = (NUM_FILTERS > 0) ? NUM_FILTERS : 1;
	localparam MODE_CFG = 2'b00;
	localparam MODE_SYNC = 2'b01;
	localparam MODE_RUN = 2'b10;

	reg sel_sleep;
	reg sel_loopback;
	reg [FW-1:0] filter_use;
	reg [1:0] mode_state;
	reg [1:0] next_mode_state;
	reg [1:0] fault;
	reg [1:0] next_fault;
	reg [8:0] tx_error_count;
	reg [8:0] next_tx_error_count;
	reg [7:0] rx_error_count;
	reg [7:0] next_rx_error_count;
	reg [7:0] runs;
	reg [7:0] next_runs;
	reg [8:0] t_step;
	reg [8:0] r_step;
	wire [`CES_EF_WIDTH-1:0] err_flags;
	reg mode_normal;
	reg mode_sleep;
	reg mode_loopback;
	reg config_ind;
	reg error_warning;
	reg bus_busy;
	reg bus_idle;
	reg tx_fifo_full;
	reg hp_buffer_full;
	reg filter_busy;
	reg [31:0] next_rdata;
	wire reset_reg_wr;
	wire soft_reset;
	wire disable_wr;
	wire enable_wr;
	wire sel_wr;
	wire flag_wr;
	wire filter_wr;
	wire run_done;
	wire [FW-1:0] filter_valid;
	wire [`CES_EF_WIDTH-1:0] err_evt;

	// ****************************************************************
	// Register write decode
	// ****************************************************************
	assign reset_reg_wr = reg_wr_i && (reg_addr_i == `CES_OFF_RESET_REGISTER);
	assign soft_reset = reset_reg_wr && reg_wdata_i[`CES_SOFT_RESET_BIT];
	assign disable_wr = reset_reg_wr && !reg_wdata_i[`CES_CORE_ENABLE_BIT];
	assign enable_wr = reset_reg_wr && !soft_reset && reg_wdata_i[`CES_CORE_ENABLE_BIT];
	assign sel_wr = reg_wr_i && (reg_addr_i == `CES_OFF_MODE_SELECT);
	assign flag_wr = reg_wr_i && (reg_addr_i == `CES_OFF_ERROR_TYPE_FLAGS);
	assign filter_wr = reg_wr_i && (reg_addr_i == `CES_OFF_FILTER_CONTROL) && (NUM_FILTERS > 0);

	// ****************************************************************
	// Recessive run detector
	// ****************************************************************
	ces_recessive_run u_run (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.can_rx_i(can_rx_i),
		.bit_tick_i(bit_tick_i),
		.restart_i(reset_reg_wr),
		.run_done_o(run_done)
	);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Soft reset clears config
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_enable_o <= 1'b0;
			sel_sleep <= 1'b0;
			sel_loopback <= 1'b0;
		end else if (soft_reset) begin
			core_enable_o <= 1'b0;
			sel_sleep <= 1'b0;
			sel_loopback <= 1'b0;
		end else begin
			if (reset_reg_wr) begin
				core_enable_o <= reg_wdata_i[`CES_CORE_ENABLE_BIT];
			end
			// Mode select only changes while disabled
			if (sel_wr && !core_enable_o) begin
				sel_sleep <= reg_wdata_i[`CES_SEL_SLEEP];
				sel_loopback <= reg_wdata_i[`CES_SEL_LOOPBACK];
			end
		end
	end

	// ****************************************************************
	// Mode sequencer
	// ****************************************************************
	always @* begin
		next_mode_state = mode_state;
		if (soft_reset || disable_wr) begin
			next_mode_state = MODE_CFG;
		end else begin
			case (mode_state)
				MODE_CFG: begin
					if (enable_wr) begin
						next_mode_state = MODE_SYNC;
					end
				end
				MODE_SYNC: begin
					if (run_done) begin
						next_mode_state = MODE_RUN;
					end
				end
				MODE_RUN: begin
					next_mode_state = MODE_RUN;
				end
				default: begin
					next_mode_state = MODE_CFG;
				end
			endcase
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_state <= MODE_CFG;
			config_ind <= `CES_CONFIG_RESET;
			mode_normal <= 1'b0;
			mode_sleep <= 1'b0;
			mode_loopback <= 1'b0;
			loopback_o <= 1'b0;
			sleep_o <= 1'b0;
		end else begin
			mode_state <= next_mode_state;
			config_ind <= (next_mode_state != MODE_RUN);
			mode_loopback <= (next_mode_state == MODE_RUN) && sel_loopback;
			mode_sleep <= (next_mode_state == MODE_RUN) && !sel_loopback && sel_sleep;
			mode_normal <= (next_mode_state == MODE_RUN) && !sel_loopback && !sel_sleep;
			loopback_o <= (next_mode_state == MODE_RUN) && sel_loopback;
			sleep_o <= (next_mode_state == MODE_RUN) && !sel_loopback && sel_sleep;
		end
	end

	// ****************************************************************
	// Fault confinement and error counters
	// ****************************************************************
	// Standard increment and decrement
	always @* begin
		t_step = tx_error_count;
		r_step = {1'b0, rx_error_count};
		if (tx_err_i) begin
			t_step = tx_error_count + `CES_ERR_STEP_MAJOR;
		end else if (tx_ok_i && (tx_error_count != 9'd0)) begin
			t_step = tx_error_count - 9'd1;
		end
		if (rx_err_major_i) begin
			r_step = {1'b0, rx_error_count} + `CES_ERR_STEP_MAJOR;
		end else if (rx_err_i) begin
			r_step = {1'b0, rx_error_count} + 9'd1;
		end else if (rx_ok_i) begin
			if ({1'b0, rx_error_count} > `CES_PASSIVE_LEVEL) begin
				r_step = `CES_RX_PASSIVE_RETURN;
			end else if (rx_error_count != 8'd0) begin
				r_step = {1'b0, rx_error_count} - 9'd1;
			end
		end
		// Receive count saturates rather than wrapping
		if (r_step > `CES_RX_CEILING) begin
			r_step = `CES_RX_CEILING;
		end
	end

	always @* begin
		next_tx_error_count = tx_error_count;
		next_rx_error_count = rx_error_count;
		next_runs = runs;
		next_fault = fault;
		if (soft_reset || disable_wr) begin
			next_tx_error_count = 9'd0;
			next_rx_error_count = 8'd0;
			next_runs = 8'd0;
			next_fault = `CES_FAULT_CONFIG;
		end else begin
			case (fault)
				`CES_FAULT_CONFIG: begin
					if (next_mode_state == MODE_RUN) begin
						next_fault = `CES_FAULT_ACTIVE;
					end
				end
				`CES_FAULT_ACTIVE, `CES_FAULT_PASSIVE: begin
					next_tx_error_count = t_step;
					next_rx_error_count = r_step[7:0];
					if (t_step > `CES_BUS_OFF_LEVEL) begin
						next_fault = `CES_FAULT_BUS_OFF;
						next_tx_error_count = 9'd0;
						next_rx_error_count = 8'd0;
						next_runs = 8'd0;
					end else if ((t_step > `CES_PASSIVE_LEVEL) || (r_step > `CES_PASSIVE_LEVEL)) begin
						next_fault = `CES_FAULT_PASSIVE;
					end else begin
						next_fault = `CES_FAULT_ACTIVE;
					end
				end
				`CES_FAULT_BUS_OFF: begin
					if (run_done) begin
						if (runs == `CES_RECOVERY_RUNS - 8'd1) begin
							next_fault = `CES_FAULT_ACTIVE;
							next_tx_error_count = 9'd0;
							next_rx_error_count = 8'd0;
							next_runs = 8'd0;
						end else begin
							next_runs = runs + 8'd1;
							next_rx_error_count = rx_error_count + 8'd1;
						end
					end
				end
				default: begin
					next_fault = `CES_FAULT_CONFIG;
				end
			endcase
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_error_count <= 9'd0;
			rx_error_count <= 8'd0;
			runs <= 8'd0;
			fault <= `CES_FAULT_CONFIG;
			bus_off_o <= 1'b0;
			error_warning <= 1'b0;
		end else begin
			tx_error_count <= next_tx_error_count;
			rx_error_count <= next_rx_error_count;
			runs <= next_runs;
			fault <= next_fault;
			bus_off_o <= (next_fault == `CES_FAULT_BUS_OFF);
			error_warning <= (next_tx_error_count >= `CES_WARN_LEVEL) ||
				({1'b0, next_rx_error_count} >= `CES_WARN_LEVEL);
		end
	end

	// ****************************************************************
	// Error type flags
	// ****************************************************************
	// Delimiter fault masks CRC
	assign err_evt[`CES_EF_ACK] = ack_err_i;
	assign err_evt[`CES_EF_BIT] = bit_err_i;
	assign err_evt[`CES_EF_STUFF] = stuff_err_i;
	assign err_evt[`CES_EF_FORM] = form_err_i;
	assign err_evt[`CES_EF_CRC] = crc_err_i && !form_err_i;

	genvar gi;
	generate
		for (gi = 0; gi < `CES_EF_WIDTH; gi = gi + 1) begin : g_flag
			// Own flop per flag keeps one driver per signal
			reg flag_bit;
			assign err_flags[gi] = flag_bit;
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					flag_bit <= 1'b0;
				end else if (soft_reset || disable_wr) begin
					flag_bit <= 1'b0;
				end else if (err_evt[gi]) begin
					flag_bit <= 1'b1;
				end else if (flag_wr && reg_wdata_i[gi]) begin
					flag_bit <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Acceptance filter control and busy
	// ****************************************************************
	assign filter_valid = (NUM_FILTERS > 0) ? {FW{1'b1}} : {FW{1'b0}};

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			filter_use <= {FW{1'b0}};
			filter_busy <= 1'b0;
			filter_locked_o <= 1'b0;
		end else if (soft_reset) begin
			filter_use <= {FW{1'b0}};
			filter_busy <= 1'b0;
			filter_locked_o <= 1'b0;
		end else begin
			if (filter_wr) begin
				filter_use <= reg_wdata_i[FW-1:0] & filter_valid;
			end
			if (filter_wr && ((~reg_wdata_i[FW-1:0] & filter_valid) != {FW{1'b0}})) begin
				filter_busy <= 1'b1;
				filter_locked_o <= 1'b1;
			end else if (filter_done_i) begin
				filter_busy <= 1'b0;
				filter_locked_o <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Status capture
	// ****************************************************************
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_busy <= 1'b0;
			bus_idle <= 1'b0;
			tx_fifo_full <= 1'b0;
			hp_buffer_full <= 1'b0;
		end else begin
			bus_busy <= (next_mode_state == MODE_RUN) && frame_active_i;
			bus_idle <= (next_mode_state == MODE_RUN) && !frame_active_i;
			tx_fifo_full <= tx_fifo_full_i;
			hp_buffer_full <= hp_buffer_full_i;
		end
	end

	// ****************************************************************
	// Register read
	// ****************************************************************
	always @* begin
		next_rdata = 32'h0000_0000;
		case (reg_addr_i)
			`CES_OFF_RESET_REGISTER: begin
				next_rdata[`CES_CORE_ENABLE_BIT] = core_enable_o;
			end
			`CES_OFF_MODE_SELECT: begin
				next_rdata[`CES_SEL_SLEEP] = sel_sleep;
				next_rdata[`CES_SEL_LOOPBACK] = sel_loopback;
			end
			`CES_OFF_ERROR_COUNTERS: begin
				next_rdata[`CES_EC_RX_HI:`CES_EC_RX_LO] = rx_error_count;
				next_rdata[`CES_EC_TX_HI:`CES_EC_TX_LO] = tx_error_count[7:0];
			end
			`CES_OFF_ERROR_TYPE_FLAGS: begin
				next_rdata[`CES_EF_WIDTH-1:0] = err_flags;
			end
			`CES_OFF_CORE_STATUS: begin
				next_rdata[`CES_ST_FILTER_BUSY] = filter_busy && (NUM_FILTERS > 0);
				next_rdata[`CES_ST_TX_FIFO_FULL] = tx_fifo_full;
				next_rdata[`CES_ST_HP_BUFFER_FULL] = hp_buffer_full;
				next_rdata[`CES_ST_FAULT_HI:`CES_ST_FAULT_LO] = config_ind ? `CES_FAULT_CONFIG : fault;
				next_rdata[`CES_ST_ERROR_WARNING] = error_warning;
				next_rdata[`CES_ST_BUS_BUSY] = bus_busy;
				next_rdata[`CES_ST_BUS_IDLE] = bus_idle;
				next_rdata[`CES_ST_NORMAL] = mode_normal;
				next_rdata[`CES_ST_SLEEP] = mode_sleep;
				next_rdata[`CES_ST_LOOPBACK] = mode_loopback;
				next_rdata[`CES_ST_CONFIG] = config_ind;
			end
			`CES_OFF_FILTER_CONTROL: begin
				next_rdata[FW-1:0] = filter_use;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Counter register has no write path
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

endmodule // ces_status_core

// File: ces_status_chk.sv
// Checker of the register port and status outputs of the error and status block
`include "ces_regs.vh"
module ces_status_chk #(
	parameter NUM_FILTERS = 4
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire [31:0] reg_rdata_o,
	input wire tx_fifo_full_i,
	input wire hp_buffer_full_i,
	input wire filter_done_i,
	input wire core_enable_o,
	input wire loopback_o,
	input wire sleep_o,
	input wire bus_off_o,
	input wire filter_locked_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire st_rd = reg_rd_i && reg_addr_i == `CES_OFF_CORE_STATUS;
	wire rst_wr = reg_wr_i && reg_addr_i == `CES_OFF_RESET_REGISTER;
	wire flt_wr = reg_wr_i && reg_addr_i == `CES_OFF_FILTER_CONTROL;
	wire [1:0] full_in = {tx_fifo_full_i, hp_buffer_full_i};
	// ****************
	// Assertions
	// ****************
	chk_reset_bit_zero: assert property (reg_rd_i && reg_addr_i == `CES_OFF_RESET_REGISTER
		|=> !reg_rdata_o[0]) else $error("soft reset bit read as one");
	chk_soft_reset_all: assert property (rst_wr && reg_wdata_i[0]
		|=> !core_enable_o && !loopback_o && !sleep_o && !bus_off_o && !filter_locked_o)
		else $error("soft reset left state behind");
	chk_disable_clears: assert property (rst_wr && !reg_wdata_i[1] |=> !core_enable_o && !bus_off_o)
		else $error("disable left bus-off or enable set");
	chk_config_status: assert property (st_rd && !core_enable_o |=> reg_rdata_o[8:0] == 9'h001)
		else $error("status wrong in configuration mode");
	chk_fault_bus_off: assert property (st_rd |=> (reg_rdata_o[8:7] == `CES_FAULT_BUS_OFF) == $past(bus_off_o))
		else $error("fault state disagrees with bus-off");
	chk_mode_bits: assert property (st_rd |=> reg_rdata_o[2:1] == {$past(sleep_o), $past(loopback_o)})
		else $error("mode bits disagree with mode outputs");
	chk_one_mode: assert property (!(loopback_o && sleep_o))
		else $error("loopback and sleep both active");
	chk_busy_idle: assert property (st_rd |=> !(reg_rdata_o[5] && reg_rdata_o[4]))
		else $error("bus busy and idle both set");
	chk_fifo_full: assert property (st_rd |=> reg_rdata_o[10:9] == $past(full_in, 2))
		else $error("full bits do not follow inputs");
	chk_filter_set: assert property (flt_wr && !(&reg_wdata_i[NUM_FILTERS-1:0]) && !filter_done_i
		|=> filter_locked_o) else $error("filter busy not set");
	chk_filter_done: assert property (filter_done_i && !flt_wr |=> !filter_locked_o)
		else $error("filter busy not cleared");
	chk_filter_bit: assert property (st_rd |=> reg_rdata_o[11] == $past(filter_locked_o))
		else $error("filter busy bit disagrees with lock");
	cov_bus_off: cover property ($rose(bus_off_o));
	cov_loopback: cover property ($rose(loopback_o));
	cov_filter: cover property ($rose(filter_locked_o));
endmodule // ces_status_chk

bind ces_status_core ces_status_chk #(.NUM_FILTERS(NUM_FILTERS)) ces_status_chk_i (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .tx_fifo_full_i(tx_fifo_full_i),
	.hp_buffer_full_i(hp_buffer_full_i), .filter_done_i(filter_done_i), .core_enable_o(core_enable_o),
	.loopback_o(loopback_o), .sleep_o(sleep_o), .bus_off_o(bus_off_o), .filter_locked_o(filter_locked_o));

// File: ces_bus_node.sv
// Behavioural model of the other nodes sharing the bus
module ces_bus_node #(
	parameter BIT_CYC = 4
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire dom_i,
	input wire frame_i,
	output wire can_rx_o,
	output logic bit_tick_o,
	output wire frame_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic alt;
	// Toggling inside a frame keeps any recessive run far below eleven bits
	assign can_rx_o = !dom_i && (!frame_i || alt);
	assign frame_active_o = frame_i;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			alt <= 1'b0;
			bit_tick_o <= 1'b0;
		end else begin
			cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
			bit_tick_o <= cnt == BIT_CYC - 1;
			alt <= alt ^ (cnt == BIT_CYC - 1);
		end
	end
endmodule // ces_bus_node

// File: tb.sv
// Self-checking bench of the error and status block
`include "ces_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_RST = `CES_OFF_RESET_REGISTER;
	localparam logic [7:0] A_SEL = `CES_OFF_MODE_SELECT;
	localparam logic [7:0] A_EC = `CES_OFF_ERROR_COUNTERS;
	localparam logic [7:0] A_EF = `CES_OFF_ERROR_TYPE_FLAGS;
	localparam logic [7:0] A_ST = `CES_OFF_CORE_STATUS;
	localparam logic [7:0] A_FLT = `CES_OFF_FILTER_CONTROL;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic [9:0] ev = 10'h000;
	logic tx_full = 1'b0;
	logic hp_full = 1'b0;
	logic f_done = 1'b0;
	logic dom = 1'b0;
	logic frame = 1'b0;
	wire [31:0] rdata;
	wire can_rx, tick, fr_act, en, lb, slp, boff, flock;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	always #4 clk_i = ~clk_i;
	ces_bus_node ces_bus_node_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .dom_i(dom), .frame_i(frame),
		.can_rx_o(can_rx), .bit_tick_o(tick), .frame_active_o(fr_act));
	ces_status_core ces_status_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
		.can_rx_i(can_rx), .bit_tick_i(tick), .frame_active_i(fr_act), .tx_err_i(ev[5]), .rx_err_i(ev[6]),
		.rx_err_major_i(ev[7]), .tx_ok_i(ev[8]), .rx_ok_i(ev[9]), .ack_err_i(ev[4]), .bit_err_i(ev[3]),
		.stuff_err_i(ev[2]), .form_err_i(ev[1]), .crc_err_i(ev[0]), .tx_fifo_full_i(tx_full),
		.hp_buffer_full_i(hp_full), .filter_done_i(f_done), .core_enable_o(en), .loopback_o(lb),
		.sleep_o(slp), .bus_off_o(boff), .filter_locked_o(flock));
	// ****************
	// Tasks
	// ****************
	task automatic conclude();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Masked read so unsettled fields can be left out of a comparison
	task automatic rc(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(name, rdata & m, exp);
	endtask
	task automatic pulse(input logic [9:0] e, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ev <= e;
			@(posedge clk_i);
			ev <= 10'h000;
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i iff tick);
	endtask
	// Ceiling well above the longest path, bus-off recovery included
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc("status", A_ST, 32'hFFFF_FFFF, 32'h0000_0001);
		rc("counters", A_EC, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("flags", A_EF, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("unmapped", 8'hF0, 32'hFFFF_FFFF, 32'h0000_0000);
		@(posedge clk_i) dom <= 1'b1;
		wr(A_RST, 32'h0000_0002);
		ticks(20);
		rc("held", A_ST, 32'h0000_0001, 32'h0000_0001);
		@(posedge clk_i) dom <= 1'b0;
		ticks(10);
		rc("short run", A_ST, 32'h0000_0001, 32'h0000_0001);
		ticks(3);
		rc("normal", A_ST, 32'h0000_0FFF, 32'h0000_0098);
		@(posedge clk_i) frame <= 1'b1;
		ticks(2);
		rc("busy", A_ST, 32'h0000_0FFF, 32'h0000_00A8);
		@(posedge clk_i) frame <= 1'b0;
		pulse(10'h020, 1);
		wr(A_EC, 32'hFFFF_FFFF);
		rc("ro", A_EC, 32'hFFFF_FFFF, 32'h0000_0008);
		pulse(10'h014, 1);
		pulse(10'h008, 1);
		rc("flags", A_EF, 32'hFFFF_FFFF, 32'h0000_001C);
		wr(A_EF, 32'h0000_0010);
		wr(A_EF, 32'h0000_0000);
		rc("w1c", A_EF, 32'hFFFF_FFFF, 32'h0000_000C);
		pulse(10'h003, 1);
		rc("crc delim", A_EF, 32'hFFFF_FFFF, 32'h0000_000E);
		pulse(10'h001, 1);
		rc("crc", A_EF, 32'hFFFF_FFFF, 32'h0000_000F);
		pulse(10'h020, 10);
		pulse(10'h040, 2);
		pulse(10'h080, 1);
		rc("counts", A_EC, 32'hFFFF_FFFF, 32'h0000_0A58);
		rc("warn 88", A_ST, 32'h0000_0040, 32'h0000_0000);
		pulse(10'h020, 1);
		rc("warn 96", A_ST, 32'h0000_0040, 32'h0000_0040);
		pulse(10'h300, 1);
		rc("ok steps", A_EC, 32'hFFFF_FFFF, 32'h0000_095F);
		rc("warn 95", A_ST, 32'h0000_0040, 32'h0000_0000);
		pulse(10'h020, 4);
		rc("active 127", A_ST, 32'h0000_0180, 32'h0000_0080);
		pulse(10'h020, 1);
		rc("passive", A_ST, 32'h0000_0180, 32'h0000_0180);
		@(posedge clk_i) dom <= 1'b1;
		pulse(10'h020, 16);
		rc("bus-off clear", A_EC, 32'hFFFF_FFFF, 32'h0000_0000);
		chk("bus off", boff, 32'h0000_0001);
		rc("bus-off", A_ST, 32'h0000_0180, 32'h0000_0100);
		@(posedge clk_i) dom <= 1'b0;
		ticks(60);
		rc("runs 5", A_EC, 32'hFFFF_FFFF, 32'h0000_0500);
		ticks(1342);
		rc("runs 127", A_EC, 32'hFFFF_FFFF, 32'h0000_7F00);
		ticks(11);
		rc("recovered", A_EC, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("active", A_ST, 32'h0000_0180, 32'h0000_0080);
		pulse(10'h020, 1);
		wr(A_RST, 32'h0000_0000);
		rc("dis counts", A_EC, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("dis flags", A_EF, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("dis status", A_ST, 32'h0000_0FFF, 32'h0000_0001);
		for (int m = 1; m <= 3; m += 2) begin
			wr(A_SEL, m);
			wr(A_RST, 32'h0000_0002);
			ticks(14);
			rc("mode", A_ST, 32'h0000_018F, (m == 3) ? 32'h0000_0082 : 32'h0000_0084);
			chk("mode outs", {slp, lb}, (m == 3) ? 32'h0000_0001 : 32'h0000_0002);
			wr(A_RST, 32'h0000_0000);
		end
		wr(A_RST, 32'h0000_0002);
		ticks(14);
		pulse(10'h020, 1);
		wr(A_RST, 32'h0000_0003);
		rc("soft bit", A_RST, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("soft counts", A_EC, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("soft mode", A_SEL, 32'hFFFF_FFFF, 32'h0000_0000);
		rc("soft status", A_ST, 32'h0000_0FFF, 32'h0000_0001);
		wr(A_FLT, 32'h0000_000F);
		rc("all used", A_ST, 32'h0000_0800, 32'h0000_0000);
		wr(A_FLT, 32'h0000_0007);
		rc("one unused", A_ST, 32'h0000_0800, 32'h0000_0800);
		rc("use bits", A_FLT, 32'hFFFF_FFFF, 32'h0000_0007);
		chk("locked", flock, 32'h0000_0001);
		@(posedge clk_i) f_done <= 1'b1;
		@(posedge clk_i) f_done <= 1'b0;
		rc("filter done", A_ST, 32'h0000_0800, 32'h0000_0000);
		@(posedge clk_i) tx_full <= 1'b1;
		rc("fifo full", A_ST, 32'h0000_0600, 32'h0000_0400);
		@(posedge clk_i) {tx_full, hp_full} <= 2'b01;
		rc("hp full", A_ST, 32'h0000_0600, 32'h0000_0200);
		@(posedge clk_i) rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc("re-reset", A_ST, 32'h0000_01FF, 32'h0000_0001);
		conclude();
	end
endmodule // tb
